// [common/qpv_pkg.sv]
// Constants, register map and control layout for the quadrature position/velocity block
package qpv_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_POSITION = 8'h08;
    localparam logic [7:0] OFS_MAXIMUM_POSITION = 8'h0c;
    localparam logic [7:0] OFS_TIMER_LOAD = 8'h10;
    localparam logic [7:0] OFS_TIMER_VALUE = 8'h14;
    localparam logic [7:0] OFS_ACCUMULATOR = 8'h18;
    localparam logic [7:0] OFS_SPEED_RESULT = 8'h1c;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h20;
    localparam logic [7:0] OFS_INT_RAW = 8'h24;
    localparam logic [7:0] OFS_INT_CLEAR = 8'h28;
    // ----------------------------------------------------------------
    // Control field positions
    // ----------------------------------------------------------------
    localparam int CTL_ENABLE = 0;
    localparam int CTL_SWAP = 1;
    localparam int CTL_SIGNAL = 2;
    localparam int CTL_CAPTURE = 3;
    localparam int CTL_RESET_SEL = 4;
    localparam int CTL_VEL_EN = 5;
    localparam int CTL_PREDIV_LO = 6;
    localparam int CTL_INV_A = 9;
    localparam int CTL_INV_B = 10;
    localparam int CTL_INV_IDX = 11;
    // ----------------------------------------------------------------
    // Status and interrupt bit positions
    // ----------------------------------------------------------------
    localparam int STAT_ERROR = 0;
    localparam int STAT_DIR = 1;
    localparam int INT_INDEX = 0;
    localparam int INT_TIMER = 1;
    localparam int INT_DIR = 2;
    localparam int INT_ERROR = 3;
    localparam int INT_BITS = 4;
    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int PREDIV_W = 3;
    localparam int PREDIV_CNT_W = 7;
    localparam logic [DATA_W-1:0] WORD_RESET = 32'h0000_0000;
    localparam logic DIR_RESET = 1'b1;

    typedef struct packed {
        logic inv_idx;
        logic inv_b;
        logic inv_a;
        logic [PREDIV_W-1:0] velocity_predivider;
        logic vel_en;
        logic position_reset_select;
        logic edge_capture_select;
        logic signal_interpretation_select;
        logic swap;
        logic enable;
    } qpv_ctl_type;
endpackage

// [common/qpv_edge_if.sv]
// Decoded edge events passed from the phase decoder to the core
`timescale 1ns/1ps
interface qpv_edge_if;
    logic step;
    logic up;
    logic any_edge;
    logic err;
    logic dir_change;
    logic dir;
    modport dec (output step, output up, output any_edge, output err, output dir_change, output dir);
    modport core (input step, input up, input any_edge, input err, input dir_change, input dir);
endinterface

// [rtl/qpv_sync.sv]
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module qpv_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Level in and out
    input wire logic d_i,
    output logic q_o
);
    typedef struct packed {
        logic meta;
        logic stable;
    } qpv_sync_type;

    qpv_sync_type s_r;
    qpv_sync_type s_nxt;

    always_comb begin
        s_nxt.meta = d_i;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_o = s_r.stable;
endmodule

// [rtl/qpv_decoder.sv]
// Phase decoder: swap, quadrature or step/direction, direction tracking
`timescale 1ns/1ps
module qpv_decoder (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Synchronised phases and setup
    input wire logic a_i,
    input wire logic b_i,
    input wire logic swap_i,
    input wire logic signal_interpretation_select_i,
    input wire logic edge_capture_select_i,
    // Decoded events
    qpv_edge_if.dec ev
);
    typedef struct packed {
        logic pa;
        logic pb;
        logic dir;
    } qpv_dec_type;

    qpv_dec_type s_r;
    qpv_dec_type s_nxt;
    logic a;
    logic b;
    logic ea;
    logic eb;
    logic new_dir;

    always_comb begin
        a = swap_i ? b_i : a_i;
        b = swap_i ? a_i : b_i;
        ea = a ^ s_r.pa;
        eb = b ^ s_r.pb;
        s_nxt.pa = a;
        s_nxt.pb = b;
        if (signal_interpretation_select_i) begin
            // A is the step clock, B the direction level
            ev.err = 1'b0;
            ev.step = ea;
            ev.up = b;
            ev.any_edge = ea;
            new_dir = b;
        end else begin
            // Both phases moving at once breaks the gray sequence
            ev.err = ea & eb;
            ev.up = ea ? (a ^ b) : ~(a ^ b);
            ev.step = ~ev.err & (ea | (edge_capture_select_i & eb));
            ev.any_edge = ~ev.err & (ea | eb);
            new_dir = ev.up;
        end
        // A reversal shows as a rise and fall on one phase only
        ev.dir_change = ev.any_edge & (new_dir != s_r.dir);
        s_nxt.dir = ev.any_edge ? new_dir : s_r.dir;
        ev.dir = s_r.dir;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_r <= '{pa: 1'b0, pb: 1'b0, dir: qpv_pkg::DIR_RESET};
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// [rtl/qpv_top.sv]
// Quadrature encoder position integrator and velocity capture with register port
`timescale 1ns/1ps
module qpv_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Encoder pins
    input wire logic phase_a_input_i,
    input wire logic phase_b_input_i,
    input wire logic index_input_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Interrupt
    output logic irq_o
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        qpv_pkg::qpv_ctl_type ctl;
        logic [31:0] position;
        logic [31:0] maximum_position;
        logic [31:0] velocity_timer_load;
        logic [31:0] timer;
        logic [31:0] velocity_accumulator;
        logic [31:0] speed_result;
        logic [qpv_pkg::PREDIV_CNT_W-1:0] prediv_cnt;
        logic [qpv_pkg::INT_BITS-1:0] int_enable;
        logic [qpv_pkg::INT_BITS-1:0] int_raw;
        logic idx_prev;
        logic [31:0] rdata;
        logic irq;
    } qpv_state_type;

    qpv_state_type s_r;
    qpv_state_type s_nxt;

    logic a_s;
    logic b_s;
    logic idx_s;
    logic a_in;
    logic b_in;
    logic idx_in;
    logic idx_rise;
    logic pos_run;
    logic vel_run;
    logic [qpv_pkg::PREDIV_CNT_W-1:0] prediv_mask;
    logic prediv_cnt_pulse;
    logic period_end;
    logic [31:0] acc_inc;
    logic [qpv_pkg::INT_BITS-1:0] ev_set;
    logic [qpv_pkg::INT_BITS-1:0] ev_clr;
    logic wr_ctl;

    qpv_edge_if ev ();

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    qpv_sync u_sync_a (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(phase_a_input_i),
        .q_o(a_s)
    );

    qpv_sync u_sync_b (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(phase_b_input_i),
        .q_o(b_s)
    );

    qpv_sync u_sync_idx (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i(index_input_i),
        .q_o(idx_s)
    );

    // Optional inversion sits after the synchronisers so it never sees a metastable level
    assign a_in = a_s ^ s_r.ctl.inv_a;
    assign b_in = b_s ^ s_r.ctl.inv_b;
    assign idx_in = idx_s ^ s_r.ctl.inv_idx;

    // ----------------------------------------------------------------
    // Phase decoder
    // ----------------------------------------------------------------
    qpv_decoder u_decoder (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .a_i(a_in),
        .b_i(b_in),
        .swap_i(s_r.ctl.swap),
        .signal_interpretation_select_i(s_r.ctl.signal_interpretation_select),
        .edge_capture_select_i(s_r.ctl.edge_capture_select),
        .ev(ev)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        pos_run = s_r.ctl.enable;
        // Velocity enable alone does nothing until the integrator runs
        vel_run = s_r.ctl.enable & s_r.ctl.vel_en;
        idx_rise = idx_in & ~s_r.idx_prev;
        s_nxt.idx_prev = idx_in;

        // ------------------------------------------------------------
        // Position integrator
        // ------------------------------------------------------------
        if (pos_run) begin
            if (s_r.ctl.position_reset_select && idx_rise) begin
                s_nxt.position = qpv_pkg::WORD_RESET;
            end else if (ev.step) begin
                if (ev.up) begin
                    // Greater-or-equal also pulls back a count left above a lowered maximum
                    if (s_r.position >= s_r.maximum_position) begin
                        s_nxt.position = qpv_pkg::WORD_RESET;
                    end else begin
                        s_nxt.position = s_r.position + 32'h0000_0001;
                    end
                end else begin
                    if (s_r.position == qpv_pkg::WORD_RESET) begin
                        // Backward from zero lands on maximum, which is edges per turn minus one
                        s_nxt.position = s_r.maximum_position;
                    end else if (s_r.position > s_r.maximum_position) begin
                        s_nxt.position = s_r.maximum_position;
                    end else begin
                        s_nxt.position = s_r.position - 32'h0000_0001;
                    end
                end
            end
        end

        // ------------------------------------------------------------
        // Velocity predivider and accumulator
        // ------------------------------------------------------------
        prediv_mask = qpv_pkg::PREDIV_CNT_W'((8'h01 << s_r.ctl.velocity_predivider) - 8'h01);
        prediv_cnt_pulse = 1'b0;
        if (vel_run && ev.step) begin
            s_nxt.prediv_cnt = s_r.prediv_cnt + 7'h01;
            // One accumulator count per two-to-the-field steps
            prediv_cnt_pulse = ((s_r.prediv_cnt & prediv_mask) == prediv_mask);
        end
        acc_inc = s_r.velocity_accumulator + {31'h0000_0000, prediv_cnt_pulse};

        // ------------------------------------------------------------
        // Velocity timer
        // ------------------------------------------------------------
        period_end = 1'b0;
        if (vel_run) begin
            if (s_r.timer == qpv_pkg::WORD_RESET) begin
                period_end = 1'b1;
                s_nxt.timer = s_r.velocity_timer_load;
            end else begin
                s_nxt.timer = s_r.timer - 32'h0000_0001;
            end
        end else begin
            // Idle timer follows the load so the first period is full length
            s_nxt.timer = s_r.velocity_timer_load;
            s_nxt.prediv_cnt = '0;
        end

        if (period_end) begin
            // An edge arriving on the closing cycle still belongs to this period
            s_nxt.speed_result = acc_inc;
            s_nxt.velocity_accumulator = qpv_pkg::WORD_RESET;
        end else if (vel_run) begin
            s_nxt.velocity_accumulator = acc_inc;
        end else begin
            s_nxt.velocity_accumulator = qpv_pkg::WORD_RESET;
        end

        // ------------------------------------------------------------
        // Interrupt events
        // ------------------------------------------------------------
        ev_set = '0;
        ev_set[qpv_pkg::INT_INDEX] = pos_run & idx_rise;
        ev_set[qpv_pkg::INT_TIMER] = period_end;
        ev_set[qpv_pkg::INT_DIR] = pos_run & ev.dir_change;
        ev_set[qpv_pkg::INT_ERROR] = pos_run & ev.err;

        ev_clr = '0;
        if (reg_wr_i && reg_addr_i == qpv_pkg::OFS_INT_CLEAR) begin
            ev_clr = reg_wdata_i[qpv_pkg::INT_BITS-1:0];
        end
        // A new event wins over a clear landing in the same cycle
        s_nxt.int_raw = (s_r.int_raw & ~ev_clr) | ev_set;

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        wr_ctl = reg_wr_i && (reg_addr_i == qpv_pkg::OFS_CONTROL);
        if (wr_ctl) begin
            s_nxt.ctl.enable = reg_wdata_i[qpv_pkg::CTL_ENABLE];
            s_nxt.ctl.swap = reg_wdata_i[qpv_pkg::CTL_SWAP];
            s_nxt.ctl.signal_interpretation_select = reg_wdata_i[qpv_pkg::CTL_SIGNAL];
            s_nxt.ctl.edge_capture_select = reg_wdata_i[qpv_pkg::CTL_CAPTURE];
            s_nxt.ctl.position_reset_select = reg_wdata_i[qpv_pkg::CTL_RESET_SEL];
            s_nxt.ctl.vel_en = reg_wdata_i[qpv_pkg::CTL_VEL_EN];
            s_nxt.ctl.velocity_predivider =
                reg_wdata_i[qpv_pkg::CTL_PREDIV_LO +: qpv_pkg::PREDIV_W];
            s_nxt.ctl.inv_a = reg_wdata_i[qpv_pkg::CTL_INV_A];
            s_nxt.ctl.inv_b = reg_wdata_i[qpv_pkg::CTL_INV_B];
            s_nxt.ctl.inv_idx = reg_wdata_i[qpv_pkg::CTL_INV_IDX];
        end
        if (reg_wr_i) begin
            case (reg_addr_i)
                qpv_pkg::OFS_POSITION: begin
                    // Software preset overrides any step in the same cycle
                    s_nxt.position = reg_wdata_i;
                end
                qpv_pkg::OFS_MAXIMUM_POSITION: begin
                    s_nxt.maximum_position = reg_wdata_i;
                end
                qpv_pkg::OFS_TIMER_LOAD: begin
                    s_nxt.velocity_timer_load = reg_wdata_i;
                end
                qpv_pkg::OFS_INT_ENABLE: begin
                    s_nxt.int_enable = reg_wdata_i[qpv_pkg::INT_BITS-1:0];
                end
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // Register reads, data valid in the following cycle only
        // ------------------------------------------------------------
        s_nxt.rdata = qpv_pkg::WORD_RESET;
        if (reg_rd_i) begin
            case (reg_addr_i)
                qpv_pkg::OFS_CONTROL: begin
                    s_nxt.rdata[qpv_pkg::CTL_ENABLE] = s_r.ctl.enable;
                    s_nxt.rdata[qpv_pkg::CTL_SWAP] = s_r.ctl.swap;
                    s_nxt.rdata[qpv_pkg::CTL_SIGNAL] = s_r.ctl.signal_interpretation_select;
                    s_nxt.rdata[qpv_pkg::CTL_CAPTURE] = s_r.ctl.edge_capture_select;
                    s_nxt.rdata[qpv_pkg::CTL_RESET_SEL] = s_r.ctl.position_reset_select;
                    s_nxt.rdata[qpv_pkg::CTL_VEL_EN] = s_r.ctl.vel_en;
                    s_nxt.rdata[qpv_pkg::CTL_PREDIV_LO +: qpv_pkg::PREDIV_W] =
                        s_r.ctl.velocity_predivider;
                    s_nxt.rdata[qpv_pkg::CTL_INV_A] = s_r.ctl.inv_a;
                    s_nxt.rdata[qpv_pkg::CTL_INV_B] = s_r.ctl.inv_b;
                    s_nxt.rdata[qpv_pkg::CTL_INV_IDX] = s_r.ctl.inv_idx;
                end
                qpv_pkg::OFS_STATUS: begin
                    s_nxt.rdata[qpv_pkg::STAT_ERROR] = s_r.int_raw[qpv_pkg::INT_ERROR];
                    s_nxt.rdata[qpv_pkg::STAT_DIR] = ev.dir;
                end
                qpv_pkg::OFS_POSITION: begin
                    s_nxt.rdata = s_r.position;
                end
                qpv_pkg::OFS_MAXIMUM_POSITION: begin
                    s_nxt.rdata = s_r.maximum_position;
                end
                qpv_pkg::OFS_TIMER_LOAD: begin
                    s_nxt.rdata = s_r.velocity_timer_load;
                end
                qpv_pkg::OFS_TIMER_VALUE: begin
                    s_nxt.rdata = s_r.timer;
                end
                qpv_pkg::OFS_ACCUMULATOR: begin
                    s_nxt.rdata = s_r.velocity_accumulator;
                end
                qpv_pkg::OFS_SPEED_RESULT: begin
                    s_nxt.rdata = s_r.speed_result;
                end
                qpv_pkg::OFS_INT_ENABLE: begin
                    s_nxt.rdata[qpv_pkg::INT_BITS-1:0] = s_r.int_enable;
                end
                qpv_pkg::OFS_INT_RAW: begin
                    s_nxt.rdata[qpv_pkg::INT_BITS-1:0] = s_r.int_raw;
                end
                qpv_pkg::OFS_INT_CLEAR: begin
                    s_nxt.rdata[qpv_pkg::INT_BITS-1:0] = s_r.int_raw & s_r.int_enable;
                end
                default: begin
                    // Unmapped or misaligned addresses read as zero
                    s_nxt.rdata = qpv_pkg::WORD_RESET;
                end
            endcase
        end

        // Masked next status is registered, so the line changes in the same cycle as the raw status
        s_nxt.irq = |(s_nxt.int_raw & s_nxt.int_enable);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign reg_rdata_o = s_r.rdata;
    assign irq_o = s_r.irq;
endmodule

// [testbench/qpv_properties.sv]
// Register port and interrupt checks on the encoder block's pins
`timescale 1ns/1ps
module qpv_properties (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // Interrupt
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside slot");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 8'h28 |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_misaligned_zero: assert property (reg_rd_i && reg_addr_i[1:0] != 2'h0 |=> reg_rdata_o == 32'h0)
        else $error("misaligned read not zero");
    a_status_reserved: assert property (reg_rd_i && reg_addr_i == 8'h04 |=> reg_rdata_o[31:2] == 30'h0)
        else $error("status high bits set");
    a_raw_reserved: assert property (reg_rd_i && reg_addr_i == 8'h24 |=> reg_rdata_o[31:4] == 28'h0)
        else $error("raw high bits set");
    a_control_readback: assert property (reg_wr_i && reg_addr_i == 8'h00 ##1
        reg_rd_i && reg_addr_i == 8'h00 |=> ((reg_rdata_o ^ $past(reg_wdata_i, 2)) & 32'hfff) == 32'h0)
        else $error("control readback");
    a_max_readback: assert property (reg_wr_i && reg_addr_i == 8'h0c ##1
        reg_rd_i && reg_addr_i == 8'h0c |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("maximum readback");
    a_irq_masked: assert property (reg_wr_i && reg_addr_i == 8'h20 && reg_wdata_i[3:0] == 4'h0 |=> !irq_o)
        else $error("irq while masked");
endmodule

bind qpv_top qpv_properties u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

// [testbench/qpv_enc_model.sv]
// Behavioural incremental encoder driving the phase and index pins
`timescale 1ns/1ps
module qpv_enc_model (
    // Clock
    input wire logic clk_i,
    // Commands
    input wire logic step_i,
    input wire logic up_i,
    input wire logic sd_i,
    input wire logic err_i,
    input wire logic idx_i,
    // Pins
    output logic pha_o,
    output logic phb_o,
    output logic idx_o
);
    logic [1:0] q = 2'h0;
    logic tick = 1'b0;
    initial {pha_o, phb_o, idx_o} = 3'h0;
    always @(posedge clk_i) begin
        idx_o <= idx_i;
        tick <= sd_i & step_i;
        if (sd_i) begin
            // Direction settles a cycle before the clock edge it qualifies
            phb_o <= up_i;
            if (tick) pha_o <= ~pha_o;
        end else begin
            // Double step flips both pins at once, an illegal jump
            if (err_i) q = q + 2'h2;
            else if (step_i) q = up_i ? q + 2'h1 : q - 2'h1;
            pha_o <= q[0] ^ q[1];
            phb_o <= q[1];
        end
    end
endmodule

// [testbench/tb_quadrature_position_velocity.sv]
// Self-checking bench for the quadrature position and velocity block
`timescale 1ns/1ps
module tb_quadrature_position_velocity;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic irq_o, phase_a_input, phase_b_input, idx;
    logic step_r = 1'b0, up_r = 1'b0, sd_r = 1'b0, err_r = 1'b0, idx_r = 1'b0;
    int num_errors = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'h763664f0;
    logic [31:0] p, d, maxv;
    logic [1:0] q = 2'h0;
    logic sw, cap;
    logic [2:0] div;

    always #20 clk_i = ~clk_i;

    qpv_enc_model enc (.clk_i(clk_i), .step_i(step_r), .up_i(up_r), .sd_i(sd_r), .err_i(err_r), .idx_i(idx_r),
        .pha_o(phase_a_input), .phb_o(phase_b_input), .idx_o(idx));
    qpv_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .phase_a_input_i(phase_a_input), .phase_b_input_i(phase_b_input),
        .index_input_i(idx), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction
    function automatic logic [31:0] nxt(input logic [31:0] x, input logic up);
        if (up) return (x == maxv) ? 32'h0 : x + 32'h1;
        return (x == 32'h0) ? maxv : x - 32'h1;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Idle cycles also drop every one-cycle strobe
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge clk_i);
            {reg_wr_i, reg_rd_i, step_r, err_r} <= 4'h0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} <= {2'h2, a, v};
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        {reg_wr_i, reg_rd_i, reg_addr_i} <= {2'h1, a};
        cyc(1);
        @(negedge clk_i);
        v = reg_rdata_o;
    endtask
    // Seven cycles per step keeps pins well under a quarter of the clock
    task automatic step(input logic up);
        if (sd_r) p = nxt(p, up);
        else begin
            if (cap | ((q[0] != up) ^ sw)) p = nxt(p, up ^ sw);
            q = up ? q + 2'h1 : q - 2'h1;
        end
        @(posedge clk_i);
        {reg_wr_i, reg_rd_i, step_r, up_r} <= {3'h1, up};
        cyc(6);
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        for (logic [7:0] a = 8'h0; a <= 8'h2c; a += 8'h4) begin
            rd(a, d);
            chk(d, (a == 8'h4) ? {30'h0, qpv_pkg::DIR_RESET, 1'b0} : 32'h0);
        end
        rd(8'h03, d);
        chk(d, 32'h0);
        maxv = 32'h9;
        wr(8'h0c, maxv);
        rd(8'h0c, d);
        chk(d, maxv);
        wr(8'h20, 32'hf);
        for (int c = 0; c < 5; c++) begin
            {sw, cap} = 2'(c);
            wr(8'h00, {28'h0, cap, c == 4, sw, 1'b1});
            rd(8'h00, d);
            chk(d, {28'h0, cap, c == 4, sw, 1'b1});
            wr(8'h08, 32'h0);
            sd_r <= (c == 4);
            cyc(1);
            p = 32'h0;
            repeat (24) begin
                seed = lfsr(seed);
                step(seed[0]);
            end
            if (c == 3) begin
                @(posedge clk_i);
                err_r <= 1'b1;
                q = q + 2'h2;
                cyc(6);
            end
            rd(8'h08, d);
            chk(d, p);
        end
        rd(8'h24, d);
        chk(d & 32'hc, 32'hc);
        wr(8'h28, 32'hf);
        rd(8'h24, d);
        chk(d, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        wr(8'h00, 32'h0);
        sd_r <= 1'b0;
        cyc(8);
        // Inverting A on steady pins makes one apparent A edge, direction from the inverted level
        wr(8'h08, 32'h5);
        wr(8'h00, 32'h209);
        cyc(6);
        rd(8'h08, d);
        chk(d, q[0] ? 32'h4 : 32'h6);
        for (int m = 1; m >= 0; m--) begin
            wr(8'h00, {27'h0, m[0], 4'h1});
            wr(8'h08, 32'h5);
            cyc(1);
            idx_r <= 1'b1;
            cyc(6);
            idx_r <= 1'b0;
            cyc(6);
            rd(8'h08, d);
            chk(d, m[0] ? 32'h0 : 32'h5);
        end
        chk({31'h0, irq_o}, 32'h1);
        wr(8'h20, 32'h0);
        rd(8'h20, d);
        chk(d, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        seed = lfsr(seed);
        div = seed[2:0];
        wr(8'h10, 32'h7cf);
        wr(8'h00, {23'h0, div, 6'h29});
        // 128 steps of 7 cycles all fall inside the first 2000-cycle period
        repeat (128) begin
            seed = lfsr(seed);
            step(seed[0]);
        end
        cyc(2000);
        rd(8'h1c, d);
        chk(d, 32'h80 >> div);
        rd(8'h18, d);
        chk(d, 32'h0);
        rd(8'h24, d);
        chk(d & 32'h2, 32'h2);
        finish_test;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        finish_test;
    end
endmodule
